// file: rtl/pmx_port_efg.sv
`timescale 1ns/10ps
`default_nettype none

module pmx_port_efg
  import pmx_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       resetn,
  input  wire logic       legacyMode,
  input  wire logic       globalPullupDisable,
  input  wire logic [7:0] portEData,
  input  wire logic [7:0] portEDir,
  input  wire logic [7:0] portFData,
  input  wire logic [7:0] portFDir,
  input  wire logic [4:0] portGData,
  input  wire logic [4:0] portGDir,
  input  wire logic       serial0ReceiverEnable,
  input  wire logic       serial0TransmitterEnable,
  input  wire logic       serial0TransmitPin,
  input  wire logic       serial0SyncModeSelect,
  input  wire logic       serial0ExtClockOut,
  input  wire logic       timer3CompareEnA,
  input  wire logic       timer3CompareEnB,
  input  wire logic       timer3CompareEnC,
  input  wire logic       timer3CompareOutA,
  input  wire logic       timer3CompareOutB,
  input  wire logic       timer3CompareOutC,
  input  wire logic [3:0] extIrqEnable,
  input  wire logic       progDownloadActive,
  input  wire logic       progSerialDataOut,
  input  wire logic       testPortEnable,
  input  wire logic       testShiftInstrState,
  input  wire logic       testShiftDataState,
  input  wire logic       testDataOut,
  input  wire logic       timer0AsyncClockSelect,
  input  wire logic       extMemoryEnable,
  input  wire logic       memWriteStrobe,
  input  wire logic       memReadStrobe,
  input  wire logic       memAddrLatchEnable,
  input  wire logic [7:0] portEPinIn,
  input  wire logic [7:0] portFPinIn,
  input  wire logic [4:0] portGPinIn,
  output logic      [7:0] portEPullup,
  output logic      [7:0] portEOutEn,
  output logic      [7:0] portEOut,
  output logic      [7:0] portEDinEnable,
  output logic      [7:0] portFPullup,
  output logic      [7:0] portFOutEn,
  output logic      [7:0] portFOut,
  output logic      [7:0] portFDinEnable,
  output logic      [4:0] portGPullup,
  output logic      [4:0] portGOutEn,
  output logic      [4:0] portGOut,
  output logic      [4:0] portGDinEnable,
  output logic            timerOscConnect,
  output logic      [7:0] portEIn,
  output logic      [7:0] portFIn,
  output logic      [4:0] portGIn,
  output logic            serial0ReceivePin,
  output logic            progSerialDataIn,
  output logic      [3:0] extIrqIn,
  output logic            timer3CaptureIn,
  output logic            timer3CountIn,
  output logic            serial0ExtClockIn,
  output logic      [3:0] analogPinPathF
);

  pmx_ovr_if ovrE ();
  pmx_ovr_if ovrF ();
  pmx_ovr_if ovrG ();

  logic [7:0] keepF;
  logic [7:0] gDinRaw;
  logic [7:0] gPuRaw;
  logic [7:0] gOeRaw;
  logic [7:0] gOvRaw;
  logic [7:0] fOeRaw;
  logic [7:0] eDinRaw;
  logic       rxForce;
  logic       txForce;
  logic       tdoDrive;
  logic       legacyG;

  // ***************************************************************
  // Port E overrides
  // ***************************************************************
  // Programming download borrows the receive and transmit pins.
  assign rxForce = serial0ReceiverEnable | progDownloadActive;
  assign txForce = serial0TransmitterEnable | progDownloadActive;

  always_comb
  begin
    ovrE.pullupOverrideEn    = 8'h00;
    ovrE.pullupOverrideVal   = 8'h00;
    ovrE.dirOverrideEn       = 8'h00;
    ovrE.dirOverrideVal      = 8'h00;
    ovrE.outValueOverrideEn  = 8'h00;
    ovrE.outValueOverrideVal = 8'h00;
    ovrE.dinEnableOverrideEn  = {extIrqEnable, 4'h0};
    ovrE.dinEnableOverrideVal = {extIrqEnable, 4'h0};
    ovrE.dirOverrideEn[PE_RX]     = rxForce;
    ovrE.pullupOverrideEn[PE_RX]  = rxForce;
    // Global disable wins over the data bit.
    ovrE.pullupOverrideVal[PE_RX] =
      portEData[PE_RX] & ~globalPullupDisable;
    ovrE.pullupOverrideEn[PE_TX]    = txForce;
    ovrE.dirOverrideEn[PE_TX]       = txForce;
    ovrE.dirOverrideVal[PE_TX]      = 1'b1;
    ovrE.outValueOverrideEn[PE_TX]  = txForce;
    ovrE.outValueOverrideVal[PE_TX] = progDownloadActive ?
                                      progSerialDataOut : serial0TransmitPin;
    ovrE.outValueOverrideEn[PE_XCK]  = serial0SyncModeSelect;
    ovrE.outValueOverrideVal[PE_XCK] = serial0ExtClockOut;
    // The compare outputs are not provided in legacy mode.
    ovrE.outValueOverrideEn[PE_OCA]  = timer3CompareEnA & ~legacyMode;
    ovrE.outValueOverrideVal[PE_OCA] = timer3CompareOutA;
    ovrE.outValueOverrideEn[PE_OCB]  = timer3CompareEnB & ~legacyMode;
    ovrE.outValueOverrideVal[PE_OCB] = timer3CompareOutB;
    ovrE.outValueOverrideEn[PE_OCC]  = timer3CompareEnC & ~legacyMode;
    ovrE.outValueOverrideVal[PE_OCC] = timer3CompareOutC;
  end

  // ***************************************************************
  // Port F overrides
  // ***************************************************************
  assign tdoDrive = testShiftInstrState | testShiftDataState;

  always_comb
  begin
    ovrF.pullupOverrideEn    = 8'h00;
    ovrF.pullupOverrideVal   = 8'h00;
    ovrF.dirOverrideEn       = 8'h00;
    ovrF.dirOverrideVal      = 8'h00;
    ovrF.outValueOverrideEn  = 8'h00;
    ovrF.outValueOverrideVal = 8'h00;
    ovrF.dinEnableOverrideEn  = 8'h00;
    ovrF.dinEnableOverrideVal = 8'h00;
    if (testPortEnable)
    begin
      ovrF.pullupOverrideEn[7:4]   = 4'hF;
      ovrF.dirOverrideEn[7:4]      = 4'hF;
      ovrF.dinEnableOverrideEn[7:4] = 4'hF;
      ovrF.pullupOverrideVal[PF_TDI] = 1'b1;
      ovrF.pullupOverrideVal[PF_TMS] = 1'b1;
      ovrF.pullupOverrideVal[PF_TCK] = 1'b1;
      ovrF.dirOverrideVal[PF_TDO]    = tdoDrive;
      ovrF.outValueOverrideEn[PF_TDO]  = 1'b1;
      ovrF.outValueOverrideVal[PF_TDO] = testDataOut;
    end
  end

  // These pull-ups are held even while reset is asserted.
  always_comb
  begin
    keepF = 8'h00;
    keepF[PF_TDI] = testPortEnable;
    keepF[PF_TMS] = testPortEnable;
    keepF[PF_TCK] = testPortEnable;
  end

  // ***************************************************************
  // Port G overrides
  // ***************************************************************
  // Legacy mode behaves as if the memory strobes always own their pins.
  assign legacyG = legacyMode;

  always_comb
  begin
    ovrG.pullupOverrideEn    = 8'h00;
    ovrG.pullupOverrideVal   = 8'h00;
    ovrG.dirOverrideEn       = 8'h00;
    ovrG.dirOverrideVal      = 8'h00;
    ovrG.outValueOverrideEn  = 8'h00;
    ovrG.outValueOverrideVal = 8'h00;
    ovrG.dinEnableOverrideEn  = 8'h00;
    ovrG.dinEnableOverrideVal = 8'h00;
    if (extMemoryEnable | legacyG)
    begin
      ovrG.pullupOverrideEn[2:0]   = 3'h7;
      ovrG.dirOverrideEn[2:0]      = 3'h7;
      ovrG.dirOverrideVal[2:0]     = 3'h7;
      ovrG.outValueOverrideEn[2:0] = 3'h7;
      ovrG.outValueOverrideVal[PG_WR]  = memWriteStrobe;
      ovrG.outValueOverrideVal[PG_RD]  = memReadStrobe;
      ovrG.outValueOverrideVal[PG_ALE] = memAddrLatchEnable;
    end
    if (timer0AsyncClockSelect | legacyG)
    begin
      ovrG.pullupOverrideEn[4:3]    = 2'h3;
      ovrG.dirOverrideEn[4:3]       = 2'h3;
      ovrG.dinEnableOverrideEn[4:3] = 2'h3;
    end
  end

  // ***************************************************************
  // Per-bit selection
  // ***************************************************************
  pmx_pin_select u_sel_e (
    .clock         (clock),
    .resetn        (resetn),
    .ovr           (ovrE),
    .portData      (portEData),
    .portDir       (portEDir),
    .pullupDisable ({8{globalPullupDisable}}),
    .keepPullup    (8'h00),
    .pullupOn      (portEPullup),
    .driveEn       (portEOutEn),
    .driveVal      (portEOut),
    .dinEnable     (eDinRaw)
  );

  pmx_pin_select u_sel_f (
    .clock         (clock),
    .resetn        (resetn),
    .ovr           (ovrF),
    .portData      (legacyMode ? 8'h00 : portFData),
    .portDir       (legacyMode ? 8'h00 : portFDir),
    .pullupDisable ({8{globalPullupDisable}}),
    .keepPullup    (keepF),
    .pullupOn      (portFPullup),
    .driveEn       (fOeRaw),
    .driveVal      (portFOut),
    .dinEnable     (portFDinEnable)
  );

  pmx_pin_select u_sel_g (
    .clock         (clock),
    .resetn        (resetn),
    .ovr           (ovrG),
    .portData      ({3'h0, portGData}),
    .portDir       ({3'h0, portGDir}),
    .pullupDisable ({8{globalPullupDisable}}),
    .keepPullup    (8'h00),
    .pullupOn      (gPuRaw),
    .driveEn       (gOeRaw),
    .driveVal      (gOvRaw),
    .dinEnable     (gDinRaw)
  );

  // Legacy mode removes every drive on port F.
  assign portFOutEn = legacyMode ? 8'h00 : fOeRaw;
  assign portEDinEnable = eDinRaw;
  assign portGPullup    = gPuRaw[4:0];
  assign portGOutEn     = gOeRaw[4:0];
  assign portGOut       = gOvRaw[4:0];
  assign portGDinEnable = gDinRaw[4:0];

  // ***************************************************************
  // Input paths to the peripherals
  // ***************************************************************
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      portEIn <= PMX_RST8;
      portFIn <= PMX_RST8;
      portGIn <= PMX_RST5;
      timerOscConnect <= 1'b0;
      analogPinPathF <= 4'h0;
    end
    else
    begin
      portEIn <= portEPinIn & eDinRaw;
      portFIn <= portFPinIn & portFDinEnable;
      portGIn <= portGPinIn & gDinRaw[4:0];
      // Legacy mode hands the oscillator pins over as well.
      timerOscConnect <= timer0AsyncClockSelect | legacyG;
      analogPinPathF <= 4'hF;
    end
  end

  assign serial0ReceivePin = portEIn[PE_RX];
  assign progSerialDataIn  = portEIn[PE_RX];
  assign extIrqIn          = portEIn[7:4];
  assign timer3CaptureIn   = portEIn[7];
  assign timer3CountIn     = portEIn[6];
  assign serial0ExtClockIn = portEIn[PE_XCK];

endmodule

`default_nettype wire

// file: rtl/pmx_pkg.sv
package pmx_pkg;

  // ***************************************************************
  // Pin counts and bit positions
  // ***************************************************************
  localparam int PMX_PORT_W = 8;
  localparam int PMX_G_W    = 5;

  localparam int PE_RX   = 0;
  localparam int PE_TX   = 1;
  localparam int PE_XCK  = 2;
  localparam int PE_OCA  = 3;
  localparam int PE_OCB  = 4;
  localparam int PE_OCC  = 5;

  localparam int PF_TCK  = 4;
  localparam int PF_TMS  = 5;
  localparam int PF_TDO  = 6;
  localparam int PF_TDI  = 7;

  localparam int PG_WR   = 0;
  localparam int PG_RD   = 1;
  localparam int PG_ALE  = 2;
  localparam int PG_OSCO = 3;
  localparam int PG_OSCI = 4;

  // ***************************************************************
  // Reset values of the registered pin controls
  // ***************************************************************
  localparam logic [7:0] PMX_RST8 = 8'h00;
  localparam logic [4:0] PMX_RST5 = 5'h00;

  // Override mode of the whole block.
  typedef enum logic [1:0] {
    PMX_MODE_NORMAL = 2'b00,
    PMX_MODE_LEGACY = 2'b01,
    PMX_MODE_PROG   = 2'b10
  } pmx_mode_e;

endpackage

// file: rtl/pmx_ovr_if.sv
`timescale 1ns/10ps
`default_nettype none

// ***************************************************************
// Override bundle of one 8-bit port
// ***************************************************************
interface pmx_ovr_if;
  logic [7:0] pullupOverrideEn;
  logic [7:0] pullupOverrideVal;
  logic [7:0] dirOverrideEn;
  logic [7:0] dirOverrideVal;
  logic [7:0] outValueOverrideEn;
  logic [7:0] outValueOverrideVal;
  logic [7:0] dinEnableOverrideEn;
  logic [7:0] dinEnableOverrideVal;
  modport src (output pullupOverrideEn, pullupOverrideVal, dirOverrideEn,
               dirOverrideVal, outValueOverrideEn, outValueOverrideVal,
               dinEnableOverrideEn, dinEnableOverrideVal);
  modport snk (input pullupOverrideEn, pullupOverrideVal, dirOverrideEn,
               dirOverrideVal, outValueOverrideEn, outValueOverrideVal,
               dinEnableOverrideEn, dinEnableOverrideVal);
endinterface

`default_nettype wire

// file: rtl/pmx_pin_select.sv
`timescale 1ns/10ps
`default_nettype none

// ***************************************************************
// Per-bit override selection with registered pin controls
// ***************************************************************
module pmx_pin_select
  import pmx_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       resetn,
  pmx_ovr_if.snk          ovr,
  input  wire logic [7:0] portData,
  input  wire logic [7:0] portDir,
  input  wire logic [7:0] pullupDisable,
  input  wire logic [7:0] keepPullup,
  output logic      [7:0] pullupOn,
  output logic      [7:0] driveEn,
  output logic      [7:0] driveVal,
  output logic      [7:0] dinEnable
);

  logic [7:0] pullupNext;
  logic [7:0] driveEnNext;
  logic [7:0] driveValNext;
  logic [7:0] dinNext;

  genvar b;
  generate
    for (b = 0; b < PMX_PORT_W; b++)
    begin : g_bit
      logic dirBit;
      logic valBit;
      // Each asserted enable picks its override value.
      assign dirBit = ovr.dirOverrideEn[b] ?
                      ovr.dirOverrideVal[b] : portDir[b];
      assign valBit = ovr.outValueOverrideEn[b] ?
                      ovr.outValueOverrideVal[b] : portData[b];
      assign pullupNext[b] = ovr.pullupOverrideEn[b] ?
                             ovr.pullupOverrideVal[b] :
                             (portData[b] & ~dirBit & ~pullupDisable[b]);
      assign driveEnNext[b]  = dirBit;
      assign driveValNext[b] = valBit;
      assign dinNext[b] = ovr.dinEnableOverrideEn[b] ?
                          ovr.dinEnableOverrideVal[b] : 1'b1;
    end
  endgenerate

  // Reset clears everything except pull-ups that must survive it.
  always_ff @(posedge clock)
  begin
    if (!resetn)
      pullupOn <= keepPullup;
    else
      pullupOn <= pullupNext | keepPullup;
  end

  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      driveEn  <= PMX_RST8;
      driveVal <= PMX_RST8;
      dinEnable <= PMX_RST8;
    end
    else
    begin
      driveEn  <= driveEnNext;
      driveVal <= driveValNext;
      dinEnable <= dinNext;
    end
  end

endmodule

`default_nettype wire

// file: bench/pmx_periph_model.sv
`timescale 1ns/10ps
`default_nettype none

// ***************************************************************
// Peripheral drivers behind the shared pins
// ***************************************************************
module pmx_periph_model
(
  input  wire logic       clock,
  input  wire logic       resetn,
  output logic      [9:0] periphReg
);
  // The register shifts one place each cycle with XNOR feedback, so a stale pin copy is caught.
  always_ff @(posedge clock)
  begin
    if (!resetn)
      periphReg <= 10'h2A5;
    else
      periphReg <= {periphReg[8:0], ~(periphReg[9] ^ periphReg[2])};
  end
endmodule

`default_nettype wire

// file: bench/pmx_port_efg_checker.sv
`timescale 1ns/10ps
`default_nettype none

module pmx_port_efg_checker
  import pmx_pkg::*;
(
  input wire logic       clock,
  input wire logic       resetn,
  input wire logic       legacyMode,
  input wire logic       globalPullupDisable,
  input wire logic [7:0] portEData,
  input wire logic [7:0] portEDir,
  input wire logic [7:0] portFDir,
  input wire logic       serial0ReceiverEnable,
  input wire logic       serial0TransmitterEnable,
  input wire logic       serial0TransmitPin,
  input wire logic       progDownloadActive,
  input wire logic       testPortEnable,
  input wire logic       testShiftInstrState,
  input wire logic       testShiftDataState,
  input wire logic       testDataOut,
  input wire logic       timer0AsyncClockSelect,
  input wire logic       extMemoryEnable,
  input wire logic [7:0] portEPullup,
  input wire logic [7:0] portEOutEn,
  input wire logic [7:0] portEOut,
  input wire logic [7:0] portEDinEnable,
  input wire logic [7:0] portFPullup,
  input wire logic [7:0] portFOutEn,
  input wire logic [7:0] portFOut,
  input wire logic [7:0] portFDinEnable,
  input wire logic [4:0] portGPullup,
  input wire logic [4:0] portGOutEn,
  input wire logic [4:0] portGDinEnable,
  input wire logic       timerOscConnect
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  a_rx_pin_input: assert property (
    $past(resetn) && $past(serial0ReceiverEnable) |-> !portEOutEn[0] &&
    portEPullup[0] == ($past(portEData[0]) && !$past(globalPullupDisable)))
    else $error("receive pin override wrong");
  a_tx_pin_drive: assert property (
    $past(resetn) && $past(serial0TransmitterEnable) &&
    !$past(progDownloadActive) |-> portEOutEn[1] && !portEPullup[1] &&
    portEOut[1] == $past(serial0TransmitPin))
    else $error("transmit pin override wrong");
  a_upper_e_plain: assert property (
    $past(resetn) |-> portEOutEn[7:4] == $past(portEDir[7:4]) &&
    portEDinEnable[7:4] == 4'hF && portEPullup[7:4] ==
    ($past(portEData[7:4]) & ~$past(portEDir[7:4]) &
    {4{!$past(globalPullupDisable)}}))
    else $error("upper port E pin overridden");
  a_legacy_f_quiet: assert property (
    legacyMode |-> portFOutEn == 8'h00)
    else $error("port F driven in legacy mode");
  a_test_pin_set: assert property (
    $past(resetn) && $past(testPortEnable) |-> portFPullup[7:4] == 4'hB &&
    portFDinEnable[7:4] == 4'h0 && {portFOutEn[7], portFOutEn[5:4]} == 3'h0)
    else $error("test port pin overrides wrong");
  a_tdo_shift_drive: assert property (
    $past(resetn) && $past(testPortEnable) && !legacyMode |->
    portFOutEn[6] == ($past(testShiftInstrState) || $past(testShiftDataState))
    && portFOut[6] == $past(testDataOut))
    else $error("test data out drive wrong");
  a_low_f_plain: assert property (
    $past(resetn) |-> portFDinEnable[3:0] == 4'hF &&
    portFOutEn[3:0] == ($past(portFDir[3:0]) & {4{!legacyMode}}))
    else $error("low port F pin overridden");
  a_osc_pins_free: assert property (
    $past(resetn) && ($past(timer0AsyncClockSelect) || $past(legacyMode))
    |-> portGPullup[4:3] == 2'h0 && portGOutEn[4:3] == 2'h0 &&
    portGDinEnable[4:3] == 2'h0 && timerOscConnect)
    else $error("oscillator pin override wrong");
  a_mem_strobe_out: assert property (
    $past(resetn) && ($past(extMemoryEnable) || $past(legacyMode)) |->
    portGOutEn[2:0] == 3'h7 && portGPullup[2:0] == 3'h0)
    else $error("memory strobe override wrong");
endmodule

bind pmx_port_efg pmx_port_efg_checker uChecker (.*);

`default_nettype wire

// file: bench/pmx_port_efg_tb.sv
`timescale 1ns/10ps
`default_nettype none

module pmx_port_efg_tb;
  import pmx_pkg::*;

  logic       clock = 1'b0;
  logic       resetn = 1'b0;
  logic       legacyMode, globalPullupDisable, serial0ReceiverEnable;
  logic       serial0TransmitterEnable, serial0SyncModeSelect;
  logic       timer3CompareEnA, timer3CompareEnB, timer3CompareEnC;
  logic       progDownloadActive, testPortEnable, testShiftInstrState;
  logic       testShiftDataState, timer0AsyncClockSelect, extMemoryEnable;
  logic       serial0TransmitPin, serial0ExtClockOut, timer3CompareOutA;
  logic       timer3CompareOutB, timer3CompareOutC, testDataOut;
  logic       memWriteStrobe, memReadStrobe, memAddrLatchEnable;
  logic       progSerialDataOut, timerOscConnect, serial0ReceivePin;
  logic       progSerialDataIn, timer3CaptureIn, timer3CountIn;
  logic       serial0ExtClockIn;
  logic [3:0] extIrqEnable, extIrqIn, analogPinPathF;
  logic [4:0] portGData, portGDir, portGPinIn, portGPullup, portGOutEn;
  logic [4:0] portGOut, portGDinEnable, portGIn;
  logic [7:0] portEData, portEDir, portFData, portFDir, portEPinIn;
  logic [7:0] portFPinIn, portEPullup, portEOutEn, portEOut, portEIn;
  logic [7:0] portEDinEnable, portFPullup, portFOutEn, portFOut, portFIn;
  logic [7:0] portFDinEnable;
  logic [9:0] periphReg, snap;
  int         errCount = 0;
  int         testsRun = 0;

  assign {progSerialDataOut, memAddrLatchEnable, memReadStrobe,
          memWriteStrobe, testDataOut, timer3CompareOutC, timer3CompareOutB,
          timer3CompareOutA, serial0ExtClockOut, serial0TransmitPin}
         = periphReg;

  pmx_port_efg DUT (.*);
  pmx_periph_model uPeriph (.clock(clock), .resetn(resetn),
                            .periphReg(periphReg));

  always #2.5 clock = ~clock;

  // ***************************************************************
  // Helpers
  // ***************************************************************
  task automatic reportAndStop;
    if (errCount == 0 && testsRun > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    testsRun++;
    if (got !== exp)
    begin
      errCount++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // The snapshot holds the peripheral value the last edge sampled.
  task automatic settle;
    @(posedge clock);
    #1;
    snap = periphReg;
    @(posedge clock);
    #1;
  endtask

  // ***************************************************************
  // Scenarios
  // ***************************************************************
  task automatic testPort;
    for (int st = 0; st < 3; st++)
    begin
      @(posedge clock);
      testShiftInstrState <= (st == 1);
      testShiftDataState <= (st == 2);
      portFDir <= 8'hFF;
      portFData <= 8'hFF;
      settle;
      chk(portFPullup, 8'hB0);
      chk(portFDinEnable, 8'h0F);
      chk(portFOutEn, {1'b0, st != 0, 6'h0F});
      chk({7'h0, portFOut[6]}, {7'h0, snap[5]});
    end
    @(posedge clock);
    resetn <= 1'b0;
    settle;
    chk(portFPullup, 8'hB0);
    @(posedge clock);
    resetn <= 1'b1;
    testPortEnable <= 1'b0;
  endtask

  task automatic plainPins;
    for (int g = 0; g < 2; g++)
    begin
      @(posedge clock);
      globalPullupDisable <= g[0];
      timer0AsyncClockSelect <= 1'b0;
      {portEData, portEDir, portFData, portFDir} <= 32'hA53C5AC3;
      {portGData, portGDir} <= 10'h2AA;
      settle;
      chk(portEPullup, g ? 8'h00 : 8'h81);
      chk(portEOutEn, 8'h3C);
      chk(portEOut, 8'hA5);
      chk(portFPullup, g ? 8'h00 : 8'h18);
      chk(portFOutEn, 8'hC3);
      chk({3'h0, portGPullup}, g ? 8'h00 : 8'h15);
      chk({3'h0, portGOut}, 8'h15);
    end
  endtask

  task automatic receivePin;
    for (int g = 0; g < 2; g++)
    begin
      @(posedge clock);
      globalPullupDisable <= g[0];
      serial0ReceiverEnable <= 1'b1;
      {portEData, portEDir, portEPinIn} <= 24'h01FF01;
      settle;
      chk(portEOutEn, 8'hFE);
      chk(portEPullup, {7'h0, !g[0]});
      chk({7'h0, serial0ReceivePin}, 8'h01);
    end
    @(posedge clock);
    {serial0ReceiverEnable, progDownloadActive} <= 2'b01;
    settle;
    chk(portEOutEn, 8'hFE);
    chk({7'h0, portEOut[1]}, {7'h0, snap[9]});
    chk({7'h0, progSerialDataIn}, 8'h01);
    @(posedge clock);
    progDownloadActive <= 1'b0;
  endtask

  task automatic transmitPins;
    @(posedge clock);
    {serial0TransmitterEnable, serial0SyncModeSelect} <= 2'b11;
    {timer3CompareEnA, timer3CompareEnB, timer3CompareEnC} <= 3'b111;
    {portEData, portEDir, portEPinIn} <= 24'hFFFCF0;
    {globalPullupDisable, extIrqEnable} <= 5'h0F;
    settle;
    chk(portEPullup, 8'h01);
    chk(portEOutEn, 8'hFE);
    chk(portEOut, {2'b11, snap[4:0], 1'b1});
    chk(portEDinEnable, 8'hFF);
    chk({3'h0, timer3CaptureIn, extIrqIn}, 8'h1F);
    chk({analogPinPathF, 1'b0, timer3CountIn, serial0ExtClockIn, 1'b0},
        8'hF4);
  endtask

  task automatic portGPins;
    for (int k = 0; k < 3; k++)
    begin
      @(posedge clock);
      timer0AsyncClockSelect <= (k == 0);
      extMemoryEnable <= (k == 1);
      legacyMode <= (k == 2);
      {portGData, portGDir, portFDir} <= 18'h3E0FF;
      settle;
      chk({3'h0, portGPullup}, {3'h0, k == 1 ? 5'h18 : 5'h07} &
          {3'h0, k == 0 ? 5'h1F : 5'h18});
      chk({3'h0, portGOutEn}, k == 0 ? 8'h00 : 8'h07);
      chk({3'h0, portGDinEnable}, k == 1 ? 8'h1F : 8'h07);
      chk({5'h0, portGOut[2:0]}, {5'h0, k ? snap[8:6] : 3'h7});
      chk({7'h0, timerOscConnect}, {7'h0, k != 1});
      chk(portFOutEn, k == 2 ? 8'h00 : 8'hFF);
    end
  endtask

  initial
  begin
    {legacyMode, globalPullupDisable, serial0ReceiverEnable} = 3'h0;
    {serial0TransmitterEnable, serial0SyncModeSelect, extIrqEnable} = 6'h0;
    {timer3CompareEnA, timer3CompareEnB, timer3CompareEnC} = 3'h0;
    {progDownloadActive, testShiftInstrState, testShiftDataState} = 3'h0;
    {timer0AsyncClockSelect, extMemoryEnable, testPortEnable} = 3'h1;
    {portEData, portEDir, portFData, portFDir} = 32'h0;
    {portEPinIn, portFPinIn, portGData, portGDir, portGPinIn} = 31'h0;
    repeat (2) @(posedge clock);
    #1;
    chk(portFPullup, 8'hB0);
    chk(portEOutEn, 8'h00);
    @(posedge clock);
    resetn <= 1'b1;
    testPort();
    plainPins();
    receivePin();
    transmitPins();
    portGPins();
    reportAndStop();
  end

  initial
  begin
    #20000;
    errCount++;
    reportAndStop();
  end
endmodule

`default_nettype wire
